// [hw/ssw_top.sv]
// Purpose: SYSREF skew guard window around the divider edge, with APB registers.
// Assumes: sysref_in and sysref_late are synchronous to core_clk.
// Notes: sysref_late marks a transition seen in the second half of the cycle.
//
// Operation
// - Ignore SYSREF inside the early window.
// - Ignore SYSREF inside the late window.
// - Early codes give 0, 0.5, 1, 1.5 clocks.
// - Late codes give 0, 0.5, 1, 1.5 clocks.
// - Code zero demands an exact edge capture.
// - Windows act only with auto adjust enabled.
// - Record captured phase; apply it plus local.
`timescale 1ns/1ps
module ssw_top (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssw_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sysref_in,
  input wire logic sysref_late,
  output logic [3:0] div_phase,
  output logic [3:0] applied_offset,
  output logic rephase_pulse
);
  // Every check in this module runs on core_clk and rests while reset is asserted.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic auto_en; // Auto phase adjust enable.
    logic [1:0] neg_win; // Early window code.
    logic [1:0] pos_win; // Late window code.
    logic [3:0] local_ofs; // Programmed local phase offset.
    logic [1:0] sr_mode; // SYSREF mode, zero disables capture.
    logic [3:0] cap_status; // Divider phase at last accepted capture.
    logic [3:0] phase; // Running divider phase in half clocks.
    logic [3:0] applied; // Applied divider offset.
    logic rephase; // One-cycle pulse on a re-phase.
    logic sr_prev; // Previous SYSREF level for edge finding.
    logic ready; // APB ready.
    logic err; // APB error.
    logic [31:0] rdata; // APB read data.
  } ssw_state_s;

  ssw_state_s st_reg; // Registered state.
  ssw_state_s st_next; // Next state.

  logic [9:0] idx; // Register index from the byte address.
  logic access; // APB access phase awaiting an answer.
  logic mapped; // Address hits a register.
  logic cap_evt; // A SYSREF rising edge is captured this cycle.
  logic [3:0] cap_phase; // Phase of that edge in half clocks.
  logic in_win; // Edge lies inside the guard window.
  logic accept; // Edge re-phases the divider.

  assign idx = paddr[ssw_pkg::ADDR_W-1:2];
  assign access = psel && penable && !st_reg.ready;
  assign mapped = (idx == ssw_pkg::IDX_LOCAL_PHASE) || (idx == ssw_pkg::IDX_DIV_CTRL) ||
                  (idx == ssw_pkg::IDX_DIV_STATUS) || (idx == ssw_pkg::IDX_SYSREF_CTRL);
  // Capture is gated by the SYSREF mode, so a disabled SYSREF never moves the divider.
  assign cap_evt = sysref_in && !st_reg.sr_prev && (st_reg.sr_mode != 2'h0);
  assign cap_phase = st_reg.phase + {3'h0, sysref_late};
  // Without auto adjust the windows are disregarded and nothing re-phases.
  assign accept = cap_evt && st_reg.auto_en && !in_win;

  ssw_window_check u_win (
    .cap_phase(cap_phase),
    .neg_win(st_reg.neg_win),
    .pos_win(st_reg.pos_win),
    .in_window(in_win)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Bus decode, divider phase and capture handling in one place.
  always_comb begin
    st_next = st_reg;
    st_next.sr_prev = sysref_in;
    st_next.rephase = 1'b0;
    st_next.ready = access;
    st_next.err = 1'b0;
    st_next.phase = st_reg.phase + ssw_pkg::HALF_PER_CLK;
    if (accept) begin
      // Record the divider phase and realign so the next edge lands on phase zero.
      st_next.cap_status = cap_phase;
      st_next.phase = st_reg.phase - cap_phase + ssw_pkg::HALF_PER_CLK;
      st_next.rephase = 1'b1;
    end
    // The applied offset follows the captured phase plus the local offset.
    st_next.applied = st_reg.cap_status + st_reg.local_ofs;
    if (access) begin
      st_next.err = !mapped; // Unmapped addresses answer with an error.
      st_next.rdata = 32'h0;
      if (pwrite && pstrb[0]) begin
        case (idx)
          ssw_pkg::IDX_LOCAL_PHASE: begin
            st_next.local_ofs = pwdata[3:0];
          end
          ssw_pkg::IDX_DIV_CTRL: begin
            // Window changes are only safe with SYSREF disabled; software sees to that.
            st_next.auto_en = pwdata[ssw_pkg::AUTO_EN_BIT];
            st_next.neg_win = pwdata[ssw_pkg::NEG_LSB+:2];
            st_next.pos_win = pwdata[ssw_pkg::POS_LSB+:2];
          end
          ssw_pkg::IDX_SYSREF_CTRL: begin
            st_next.sr_mode = pwdata[ssw_pkg::MODE_LSB+:2];
          end
          default: begin
            st_next.rdata = 32'h0; // Status and unmapped writes are ignored.
          end
        endcase
      end else if (!pwrite) begin
        case (idx)
          ssw_pkg::IDX_LOCAL_PHASE: begin
            st_next.rdata = {28'h0, st_reg.local_ofs};
          end
          ssw_pkg::IDX_DIV_CTRL: begin
            st_next.rdata = {24'h0, st_reg.auto_en, 3'h0, st_reg.neg_win,
                             st_reg.pos_win};
          end
          ssw_pkg::IDX_DIV_STATUS: begin
            // Software checks its window sum against this value before enabling.
            st_next.rdata = {28'h0, st_reg.cap_status};
          end
          ssw_pkg::IDX_SYSREF_CTRL: begin
            st_next.rdata = {29'h0, st_reg.sr_mode, 1'b0};
          end
          default: begin
            st_next.rdata = 32'h0;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // All control state takes constants under reset.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.neg_win <= ssw_pkg::WIN_RST;
      st_reg.pos_win <= ssw_pkg::WIN_RST;
      st_reg.local_ofs <= ssw_pkg::PHASE_RST;
      st_reg.cap_status <= ssw_pkg::PHASE_RST;
      st_reg.sr_mode <= ssw_pkg::MODE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.err;
  assign div_phase = st_reg.phase;
  assign applied_offset = st_reg.applied;
  assign rephase_pulse = st_reg.rephase;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_ctrl_write;
    psel && penable && !pready && pwrite && pstrb[0] && (idx == ssw_pkg::IDX_DIV_CTRL);
  endsequence
  sequence s_accept;
    accept;
  endsequence

  a_neg_ignored: assert property (
    cap_evt && st_reg.auto_en && cap_phase[3] && ((4'h0 - cap_phase) <= {2'h0, st_reg.neg_win})
    |=> !rephase_pulse && $stable(st_reg.cap_status))
    else $error("Early capture inside window re-phased the divider.");
  a_pos_ignored: assert property (
    cap_evt && st_reg.auto_en && !cap_phase[3] && (cap_phase <= {2'h0, st_reg.pos_win})
    |=> !rephase_pulse && $stable(st_reg.cap_status))
    else $error("Late capture inside window re-phased the divider.");
  a_neg_code: assert property (
    (cap_phase == 4'hd) |-> (in_win == (st_reg.neg_win == 2'h3)))
    else $error("Early code three does not span three half clocks.");
  a_pos_code: assert property (
    (cap_phase == 4'h2) |-> (in_win == (st_reg.pos_win >= 2'h2)))
    else $error("Late window code does not span its half clocks.");
  a_zero_exact: assert property (
    cap_evt && st_reg.auto_en && (st_reg.neg_win == 2'h0) && (st_reg.pos_win == 2'h0) &&
    (cap_phase != 4'h0) |=> rephase_pulse)
    else $error("Zero windows tolerated an off-edge capture.");
  a_auto_off: assert property (
    !st_reg.auto_en |=> !rephase_pulse && $stable(st_reg.cap_status))
    else $error("Divider re-phased with auto adjust disabled.");
  a_capture_rec: assert property (
    s_accept |=> (st_reg.cap_status == $past(cap_phase)) ##1
    (applied_offset == st_reg.cap_status + st_reg.local_ofs))
    else $error("Captured phase or applied offset wrong.");
  a_window_rw: assert property (
    s_ctrl_write |=> (st_reg.neg_win == $past(pwdata[3:2])) &&
    (st_reg.pos_win == $past(pwdata[1:0])) && pready)
    else $error("Window fields did not take the written value.");
  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("Ready held longer than one cycle.");
  a_phase_step: assert property (
    !accept |=> (div_phase == $past(div_phase) + ssw_pkg::HALF_PER_CLK))
    else $error("Divider phase did not advance by one clock.");
  a_phase_align: assert property (
    s_accept |=> (div_phase == $past(div_phase) - $past(cap_phase) + ssw_pkg::HALF_PER_CLK))
    else $error("Divider phase was not realigned to the capture.");
  a_unmapped_err: assert property (
    access && !mapped |=> pready && pslverr && (prdata == 32'h0))
    else $error("Unmapped access did not answer with an error.");
endmodule : ssw_top

// [hw/ssw_pkg.sv]
// Purpose: Shared constants for the SYSREF skew window block.
// Assumes: Registers are byte addressed at four times their index.
// Notes: All phases are counted in half device-clock units.
package ssw_pkg;
  // ****************************************************************
  // Register indices and bus geometry
  // ****************************************************************
  localparam int unsigned ADDR_W = 12; // Byte address width of the slave.
  localparam logic [9:0] IDX_LOCAL_PHASE = 10'h109; // Local divider phase offset.
  localparam logic [9:0] IDX_DIV_CTRL = 10'h10a; // Divider and SYSREF control.
  localparam logic [9:0] IDX_DIV_STATUS = 10'h10b; // Captured divider phase.
  localparam logic [9:0] IDX_SYSREF_CTRL = 10'h120; // SYSREF mode control.
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned AUTO_EN_BIT = 7; // Auto phase adjust enable.
  localparam int unsigned NEG_LSB = 2; // Negative window field [3:2].
  localparam int unsigned POS_LSB = 0; // Positive window field [1:0].
  localparam int unsigned MODE_LSB = 1; // SYSREF mode field [2:1].
  // ****************************************************************
  // Reset values and divider geometry
  // ****************************************************************
  localparam logic [1:0] WIN_RST = 2'h0; // Both windows reset to no tolerance.
  localparam logic [3:0] PHASE_RST = 4'h0; // Phase fields reset to zero.
  localparam logic [1:0] MODE_RST = 2'h0; // SYSREF disabled after reset.
  localparam logic [3:0] HALF_PER_CLK = 4'h2; // Half clocks per core clock.
endpackage : ssw_pkg

// [hw/ssw_window_check.sv]
// Purpose: Decides whether a SYSREF capture phase lies inside the guard window.
// Assumes: Phase 0 is the divider edge; the phase wraps every 16 half clocks.
// Notes: Pure combinational logic, used by the top block.
`timescale 1ns/1ps
module ssw_window_check (
  input wire logic [3:0] cap_phase,
  input wire logic [1:0] neg_win,
  input wire logic [1:0] pos_win,
  output logic in_window
);
  // ****************************************************************
  // Window test
  // ****************************************************************
  // Late captures count up from the edge, early ones count back from 16.
  logic [3:0] early_dist;
  always_comb begin
    early_dist = 4'h0 - cap_phase;
    if (cap_phase == 4'h0) begin
      in_window = 1'b1; // Exact hit never disturbs the divider.
    end else if (cap_phase[3] == 1'b0) begin
      in_window = (cap_phase <= {2'h0, pos_win});
    end else begin
      in_window = (early_dist <= {2'h0, neg_win});
    end
  end
endmodule : ssw_window_check

// [verif/ssw_sysref_src.sv]
// Purpose: Behavioural SYSREF source facing the skew window block.
// Assumes: The bench raises fire right after a rising edge, for one cycle.
// Notes: The late qualifier carries meaning only while a transition is launched.
`timescale 1ns/1ps
module ssw_sysref_src (
  input wire logic core_clk,
  input wire logic fire,
  input wire logic late,
  output logic sysref_in,
  output logic sysref_late
);
  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Each request gives one clean low-to-high step; the bench keeps a low cycle between them.
  assign sysref_in = fire;
  // Outside a launch the qualifier is stale, so the inverse is shown to catch misuse.
  assign sysref_late = fire ? late : ~late;
endmodule : ssw_sysref_src

// [verif/ssw_top_tb.sv]
// Purpose: Self-checking bench for the SYSREF skew window block.
// Assumes: The APB slave answers with one wait state.
// Notes: Capture phases are steered by waiting for div_phase before launching.
`timescale 1ns/1ps
module ssw_top_tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ssw_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic fire = 1'b0;
  logic late = 1'b0;
  logic sysref_in, sysref_late, pready, pslverr, rephase_pulse, err;
  logic [31:0] prdata, rd;
  logic [3:0] div_phase, applied_offset;
  logic [1:0] ng, ps;
  int miscompares = 0;
  int cmp_count = 0;
  // The clock toggles every 2.5 ns, for a period of 5 ns.
  always #2.5 core_clk = ~core_clk;
  ssw_top u_ssw_top (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .sysref_in, .sysref_late, .div_phase,
    .applied_offset, .rephase_pulse);
  ssw_sysref_src u_ssw_sysref_src (.core_clk, .fire, .late, .sysref_in, .sysref_late);
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // No wait count is assumed here; only the watchdog ends a stuck transfer.
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk("read data", exp, rd);
    chk("slave error", {31'h0, e}, {31'h0, err});
  endtask : rdchk
  // Launches a SYSREF step that is captured at phase cap and checks the re-phase pulse.
  task automatic shot(input logic [3:0] cap, input logic [1:0] n_w, input logic [1:0] p_w,
    input logic on);
    logic [3:0] gap;
    logic [3:0] ph_exp;
    logic hit;
    int n;
    hit = on && cap != 4'h0 && !(cap <= 4'h7 && cap <= {2'h0, p_w})
      && !(cap >= 4'h8 && 5'h10 - {1'b0, cap} <= {3'h0, n_w});
    n = 0;
    // A late-half capture leaves the divider on odd phases, so the launch edge is picked
    // for either parity and the late qualifier supplies the missing half clock.
    do begin
      @(posedge core_clk);
      n++;
      gap = cap - div_phase - 4'h2;
    end while (gap > 4'h1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      $display("[FAIL] phase steer expected launch seen timeout");
    end
    fire <= 1'b1;
    late <= gap[0];
    @(posedge core_clk);
    fire <= 1'b0;
    // A re-phase puts the capture point at phase zero, so the divider then reads two half clocks less the late half.
    ph_exp = hit ? 4'h2 - {3'h0, gap[0]} : cap - {3'h0, gap[0]} + 4'h2;
    @(posedge core_clk);
    chk("rephase pulse", {31'h0, hit}, {31'h0, rephase_pulse});
    chk("divider phase", {28'h0, ph_exp}, {28'h0, div_phase});
  endtask : shot
  // Prints the counts and the verdict, then stops the run.
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Watchdog: the whole sequence needs well under a few thousand cycles.
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    rdchk(12'h428, 32'h0, 1'b0);
    rdchk(12'h42c, 32'h0, 1'b0);
    rdchk(12'h400, 32'h0, 1'b1);
    apb(1'b1, 12'h424, 32'h5);
    // One capture with both windows closed leaves a status that later window sums stay under.
    apb(1'b1, 12'h428, 32'h80);
    apb(1'b1, 12'h480, 32'h2);
    shot(4'h7, 2'h0, 2'h0, 1'b1);
    rdchk(12'h42c, 32'h7, 1'b0);
    $display("test reset_and_map done");
    // Every code on both sides, with asymmetric windows so a swap shows up.
    // The window sum is always three, below the low status bits left by the last capture.
    for (int c = 0; c < 4; c++) begin
      ng = c[1:0];
      ps = ~ng;
      apb(1'b1, 12'h480, 32'h0);
      apb(1'b1, 12'h428, {24'h0, 4'h8, ng, ps});
      rdchk(12'h428, {24'h0, 4'h8, ng, ps}, 1'b0);
      apb(1'b1, 12'h480, 32'h2);
      shot({2'h0, ps}, ng, ps, 1'b1);
      shot({2'h0, ps} + 4'h1, ng, ps, 1'b1);
      shot(4'h0 - {2'h0, ng}, ng, ps, 1'b1);
      shot(4'hf - {2'h0, ng}, ng, ps, 1'b1);
      rdchk(12'h42c, {28'h0, 4'hf - {2'h0, ng}}, 1'b0);
      chk("applied offset", {28'h0, 4'h4 - {2'h0, ng}}, {28'h0, applied_offset});
    end
    $display("test window_codes done");
    // The status is read-only; a disabled capture or a cleared enable changes nothing.
    apb(1'b1, 12'h42c, 32'hf);
    rdchk(12'h42c, 32'hc, 1'b0);
    apb(1'b1, 12'h480, 32'h0);
    apb(1'b1, 12'h428, 32'h80);
    shot(4'h7, 2'h0, 2'h0, 1'b0);
    apb(1'b1, 12'h428, 32'h0);
    apb(1'b1, 12'h480, 32'h2);
    shot(4'h7, 2'h0, 2'h0, 1'b0);
    rdchk(12'h42c, 32'hc, 1'b0);
    $display("test gating done");
    give_verdict();
  end
endmodule : ssw_top_tb
